/* rtl/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------
    localparam int WORD_W       = 24;
    localparam int CMD_MSB      = 23;
    localparam int CMD_LSB      = 20;
    localparam int ADDR_MSB     = 19;
    localparam int ADDR_LSB     = 16;
    localparam int CODE_MSB     = 15;
    localparam int CODE12_LSB   = 4;
    localparam int PD_MODE_MSB  = 9;
    localparam int PD_MODE_LSB  = 8;
    localparam int NUM_CHAN     = 8;
    localparam int CODE_W       = 16;

    // ------------------------------------------------------------
    // commands and addresses
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WRITE_IN     = 4'h0;
    localparam logic [3:0] CMD_UPDATE       = 4'h1;
    localparam logic [3:0] CMD_WRITE_UPDALL = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPD    = 4'h3;
    localparam logic [3:0] CMD_PWRDN        = 4'h4;
    localparam logic [3:0] CMD_CLEAR_CODE   = 4'h5;
    localparam logic [3:0] CMD_LOAD_OVR     = 4'h6;
    localparam logic [3:0] CMD_SOFT_RESET   = 4'h7;
    localparam logic [3:0] CMD_REF_SETUP    = 4'h8;
    localparam logic [3:0] ADDR_ALL         = 4'hF;

    // ------------------------------------------------------------
    // codes and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID  = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hFFFF;
    localparam logic [1:0]  CLR_SEL_ZERO = 2'h0;
    localparam logic [1:0]  CLR_SEL_MID  = 2'h1;
    localparam logic [1:0]  CLR_SEL_FULL = 2'h2;
    localparam logic [1:0]  CLR_SEL_NOP  = 2'h3;
    localparam logic [1:0]  PD_NORMAL    = 2'h0;
    localparam logic [1:0]  PD_1K        = 2'h1;
    localparam logic [1:0]  PD_100K      = 2'h2;
    localparam logic [1:0]  PD_TRISTATE  = 2'h3;
    localparam logic        REF_RESET    = 1'b0;
    localparam logic [1:0]  CLR_SEL_RESET = CLR_SEL_ZERO;

    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } cmd_word_t;

    typedef struct packed {
        logic        to_1k;
        logic        to_100k;
        logic        tristate;
        logic        amp_on;
    } out_term_t;

endpackage

/* rtl/pin_sync.sv */
module pin_sync
    import dac_ctrl_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic core_clk, // system clock
    input  wire logic rst,      // sync reset
    input  wire logic pin_in,   // async pin
    output logic      pin_out   // synchronised level
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            pin_out  <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            pin_out  <= sync_next;
        end
    end
endmodule

/* rtl/octal_dac_command_control.sv */
// Function
// - after power-on every output holds power-on code until first valid write
// - command 0111 resets everything as power-on does
// - load strobe and clear pin ignored during power-on reset
// - word: command 23..20, address 19..16, code 15..0, msb first
// - 12-bit variant: code in 15..4, bits 3..0 ignored
// - command 0100 power-down, mode from bits 9 and 8
// - power-down bits 7..0 select channels H..A
// - mode 00 gives normal amplifier-driven output
// - mode 01 1k to ground, 10 100k, 11 three-state
// - reference powers down only when all eight channels are down
// - power-down keeps converter register contents
// - power-up shows input register if strobe low, else converter register
// - clear falling edge loads input and converter registers with clear code
// - command 0101 loads clear select from bits 1..0
// - clear select 00 zero, 01 mid, 10 full, 11 no operation
// - clear select resets to zero scale
// - clear mode held until next valid write completes
// - clear edge during a write aborts that write
// - reference bit 0: 1 on, 0 off, resets off
// - command 1000 sets reference, address and bits 15..1 ignored
// - load strobe updates all converter registers simultaneously
// - address 0..7 selects A..H, 1111 selects all
// - load strobe low loads converter from input register
// - override bit 1 updates converter right after new data
module octal_dac_command_control
    import dac_ctrl_pkg::*;
#(
    parameter int  CODE_BITS = 16,   // 16 or 12
    parameter bit  MIDSCALE  = 1'b0  // power-on to midscale variant
) (
    input  wire logic                core_clk,       // 250 MHz clock
    input  wire logic                rst,            // power-on reset
    input  wire logic                word_valid,     // received word complete
    input  wire logic [WORD_W-1:0]   word_data,      // received 24-bit word
    input  wire logic                write_busy,     // a write sequence is in progress
    input  wire logic                load_strobe_n,  // hardware load pin
    input  wire logic                async_clear_n,  // clear pin
    output logic [NUM_CHAN*CODE_W-1:0] dac_code,     // per-channel output codes
    output logic [NUM_CHAN-1:0]      amp_on,         // amplifier drives output
    output logic [NUM_CHAN-1:0]      term_1k,        // 1k to ground
    output logic [NUM_CHAN-1:0]      term_100k,      // 100k to ground
    output logic [NUM_CHAN-1:0]      term_tristate,  // output open
    output logic                     ref_on,         // internal reference powered
    output logic                     clear_mode,     // clear code mode active
    output logic                     write_abort     // pending write aborted
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic ld_sync;
    logic clr_sync;

    pin_sync #(.RESET_VAL(1'b1)) u_ld_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (load_strobe_n),
        .pin_out  (ld_sync)
    );

    pin_sync #(.RESET_VAL(1'b1)) u_clr_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   (async_clear_n),
        .pin_out  (clr_sync)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam logic [15:0] POR_CODE = MIDSCALE ? CODE_MID : CODE_ZERO;
    localparam logic [15:0] CODE_MASK =
        (CODE_BITS == 12) ? 16'hFFF0 : 16'hFFFF;

    logic [CODE_W-1:0]   in_reg   [NUM_CHAN];
    logic [CODE_W-1:0]   in_next  [NUM_CHAN];
    logic [CODE_W-1:0]   dac_reg  [NUM_CHAN];
    logic [CODE_W-1:0]   dac_next [NUM_CHAN];
    logic [1:0]          pd_reg   [NUM_CHAN];
    logic [1:0]          pd_next  [NUM_CHAN];
    logic [NUM_CHAN-1:0] ovr_reg, ovr_next;
    logic [1:0]          clr_sel_reg, clr_sel_next;
    logic                ref_reg, ref_next;
    logic                clr_mode_reg, clr_mode_next;
    logic                clr_prev_reg;
    logic                por_reg, por_next;
    logic                abort_reg, abort_next;
    logic                drop_reg, drop_next;

    cmd_word_t           w;
    logic [CODE_W-1:0]   code_in;
    logic [NUM_CHAN-1:0] sel;
    logic                clr_fall;
    logic                ld_fall;
    logic                soft_rst;
    logic [CODE_W-1:0]   clr_code;
    logic                all_down;
    logic                take;
    logic                clr_hit;
    logic [NUM_CHAN*CODE_W-1:0] code_next;
    logic [NUM_CHAN-1:0] amp_next;
    logic [NUM_CHAN-1:0] t1k_next;
    logic [NUM_CHAN-1:0] t100k_next;
    logic [NUM_CHAN-1:0] ttri_next;
    logic                ref_on_next;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        w        = word_data;
        code_in  = w.data & CODE_MASK;
        for (int i = 0; i < NUM_CHAN; i++) begin
            sel[i] = (w.addr == ADDR_ALL) || (w.addr == 4'(i));
        end
        // pins are ignored while the power-on reset window is open
        clr_fall = !por_reg && clr_prev_reg && !clr_sync;
        ld_fall  = !por_reg && !ld_sync;
        if (clr_sel_reg == CLR_SEL_ZERO) begin
            clr_code = CODE_ZERO;
        end else if (clr_sel_reg == CLR_SEL_MID) begin
            clr_code = CODE_MID;
        end else begin
            clr_code = CODE_FULL;
        end
        clr_hit  = clr_fall && (clr_sel_reg != CLR_SEL_NOP);
        // a clear edge kills the word of its own cycle and any later word of that frame
        take     = word_valid && !clr_hit && !drop_reg;
        soft_rst = take && (w.cmd == CMD_SOFT_RESET);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        por_next       = 1'b0;
        ovr_next       = ovr_reg;
        clr_sel_next   = clr_sel_reg;
        ref_next       = ref_reg;
        clr_mode_next  = clr_mode_reg;
        abort_next     = 1'b0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            in_next[i]  = in_reg[i];
            dac_next[i] = dac_reg[i];
            pd_next[i]  = pd_reg[i];
        end

        if (clr_hit) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                in_next[i]  = clr_code;
                dac_next[i] = clr_code;
            end
            clr_mode_next = 1'b1;
            abort_next    = word_valid || write_busy;
        end else if (take) begin
            clr_mode_next  = 1'b0;
            case (w.cmd)
                CMD_WRITE_IN, CMD_WRITE_UPD, CMD_WRITE_UPDALL: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if (sel[i]) begin
                            in_next[i] = code_in;
                        end
                    end
                end
                CMD_PWRDN: begin
                    for (int i = 0; i < NUM_CHAN; i++) begin
                        if (w.data[i]) begin
                            pd_next[i] = w.data[PD_MODE_MSB:PD_MODE_LSB];
                        end
                    end
                end
                CMD_CLEAR_CODE: clr_sel_next = w.data[1:0];
                CMD_LOAD_OVR:   ovr_next = w.data[NUM_CHAN-1:0];
                CMD_REF_SETUP:  ref_next = w.data[0];
                default: ;
            endcase
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (w.cmd == CMD_UPDATE && sel[i]) begin
                    dac_next[i] = in_reg[i];
                end else if (w.cmd == CMD_WRITE_UPD && sel[i]) begin
                    dac_next[i] = code_in;
                end else if (w.cmd == CMD_WRITE_UPDALL) begin
                    dac_next[i] = in_next[i];
                end else if ((ovr_reg[i] || !ld_sync) && w.cmd == CMD_WRITE_IN
                             && sel[i]) begin
                    dac_next[i] = code_in;
                end
            end
        end else begin
            // strobe held low keeps converter registers tracking inputs
            for (int i = 0; i < NUM_CHAN; i++) begin
                if (ld_fall || (ovr_reg[i] && !por_reg)) begin
                    dac_next[i] = in_reg[i];
                end
            end
        end

        if (soft_rst) begin
            ovr_next       = '0;
            clr_sel_next   = CLR_SEL_RESET;
            ref_next       = REF_RESET;
            clr_mode_next  = 1'b0;
            por_next       = 1'b1;
            for (int i = 0; i < NUM_CHAN; i++) begin
                in_next[i]  = POR_CODE;
                dac_next[i] = POR_CODE;
                pd_next[i]  = PD_NORMAL;
            end
        end
    end

    // ------------------------------------------------------------
    // write abort tracking
    // ------------------------------------------------------------
    // a clear while a frame is still arriving poisons that whole frame,
    // not only the word that happens to land in the clear cycle
    always_comb begin
        drop_next = drop_reg && write_busy;
        if (clr_hit && write_busy && !word_valid) begin
            drop_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            por_reg       <= 1'b1;
            ovr_reg       <= '0;
            clr_sel_reg   <= CLR_SEL_RESET;
            ref_reg       <= REF_RESET;
            clr_mode_reg  <= 1'b0;
            clr_prev_reg  <= 1'b1;
            abort_reg     <= 1'b0;
            drop_reg      <= 1'b0;
            for (int i = 0; i < NUM_CHAN; i++) begin
                in_reg[i]  <= POR_CODE;
                dac_reg[i] <= POR_CODE;
                pd_reg[i]  <= PD_NORMAL;
            end
        end else begin
            por_reg       <= por_next;
            ovr_reg       <= ovr_next;
            clr_sel_reg   <= clr_sel_next;
            ref_reg       <= ref_next;
            clr_mode_reg  <= clr_mode_next;
            clr_prev_reg  <= clr_sync;
            abort_reg     <= abort_next;
            drop_reg      <= drop_next;
            for (int i = 0; i < NUM_CHAN; i++) begin
                in_reg[i]  <= in_next[i];
                dac_reg[i] <= dac_next[i];
                pd_reg[i]  <= pd_next[i];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        all_down = 1'b1;
        for (int i = 0; i < NUM_CHAN; i++) begin
            all_down = all_down && (pd_reg[i] != PD_NORMAL);
        end
        code_next  = '0;
        amp_next   = '0;
        t1k_next   = '0;
        t100k_next = '0;
        ttri_next  = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            // powered-down channel still shows its held code once back up
            code_next[i*CODE_W +: CODE_W] = dac_reg[i];
            amp_next[i]   = (pd_reg[i] == PD_NORMAL);
            t1k_next[i]   = (pd_reg[i] == PD_1K);
            t100k_next[i] = (pd_reg[i] == PD_100K);
            ttri_next[i]  = (pd_reg[i] == PD_TRISTATE);
        end
        ref_on_next = ref_reg && !all_down;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dac_code      <= {NUM_CHAN{POR_CODE}};
            amp_on        <= '1;
            term_1k       <= '0;
            term_100k     <= '0;
            term_tristate <= '0;
            ref_on        <= 1'b0;
            clear_mode    <= 1'b0;
            write_abort   <= 1'b0;
        end else begin
            dac_code      <= code_next;
            amp_on        <= amp_next;
            term_1k       <= t1k_next;
            term_100k     <= t100k_next;
            term_tristate <= ttri_next;
            ref_on        <= ref_on_next;
            clear_mode    <= clr_mode_reg;
            write_abort   <= abort_reg;
        end
    end
endmodule

/* tb/octal_dac_command_control_properties.sv */
module octal_dac_command_control_properties
    import dac_ctrl_pkg::*;
#(
    parameter int CODE_BITS = 16,  // code width of the variant
    parameter bit MIDSCALE  = 1'b0 // power-on code choice
) (
    input wire logic                     core_clk,      // clock
    input wire logic                     rst,           // sync reset
    input wire logic                     word_valid,    // word pulse
    input wire logic [WORD_W-1:0]        word_data,     // word
    input wire logic                     write_busy,    // write in progress
    input wire logic                     load_strobe_n, // load pin
    input wire logic                     async_clear_n, // clear pin
    input wire logic [NUM_CHAN*CODE_W-1:0] dac_code,    // codes
    input wire logic [NUM_CHAN-1:0]      amp_on,        // amplifier on
    input wire logic [NUM_CHAN-1:0]      term_1k,       // 1k load
    input wire logic [NUM_CHAN-1:0]      term_100k,     // 100k load
    input wire logic [NUM_CHAN-1:0]      term_tristate, // open output
    input wire logic                     ref_on,        // reference on
    input wire logic                     clear_mode,    // clear mode
    input wire logic                     write_abort    // abort pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    cmd_word_t  w;
    logic [5:0] clr_hist;
    logic       quiet;
    assign w = word_data;
    assign quiet = clr_hist == 6'h3F;
    // pin history lets a word near a clear edge be left out
    always_ff @(posedge core_clk) begin
        clr_hist <= {clr_hist[4:0], async_clear_n};
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_reset;
        $fell(rst) |-> dac_code == {NUM_CHAN{(MIDSCALE ? CODE_MID : CODE_ZERO)}}
            && amp_on == 8'hFF && !ref_on && !clear_mode;
    endproperty
    a_reset: assert property (p_reset) else $error("bad state after reset");
    property p_onehot;
        (amp_on | term_1k | term_100k | term_tristate) == 8'hFF
            && ((amp_on & (term_1k | term_100k | term_tristate))
            | (term_1k & (term_100k | term_tristate)) | (term_100k & term_tristate)) == 8'h00;
    endproperty
    a_onehot: assert property (p_onehot) else $error("output stage not one-hot");
    property p_ref_alive;
        ref_on |-> amp_on != 8'h00;
    endproperty
    a_ref_alive: assert property (p_ref_alive) else $error("reference on, all down");
    property p_soft;
        quiet && word_valid && w.cmd == CMD_SOFT_RESET
            |-> ##2 (!ref_on && !clear_mode && amp_on == 8'hFF && term_1k == 8'h00);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset incomplete");
    property p_ref_set;
        quiet && word_valid && w.cmd == CMD_REF_SETUP && w.data[0] && amp_on != 8'h00
            && !$past(word_valid) |-> ##2 ref_on;
    endproperty
    a_ref_set: assert property (p_ref_set) else $error("reference not on");
    property p_pd_1k;
        quiet && word_valid && w.cmd == CMD_PWRDN && w.data[9:8] == PD_1K && w.data[0]
            |-> ##2 term_1k[0];
    endproperty
    a_pd_1k: assert property (p_pd_1k) else $error("1k mode missing");
    property p_pd_up;
        quiet && word_valid && w.cmd == CMD_PWRDN && w.data[9:8] == PD_NORMAL && w.data[0]
            |-> ##2 amp_on[0];
    endproperty
    a_pd_up: assert property (p_pd_up) else $error("power-up missing");
    property p_clr_rise;
        $rose(clear_mode) |-> clr_hist != 6'h3F;
    endproperty
    a_clr_rise: assert property (p_clr_rise) else $error("clear mode w/o pin");
    property p_clr_fall;
        $fell(clear_mode) |-> $past(word_valid, 2);
    endproperty
    a_clr_fall: assert property (p_clr_fall) else $error("clear mode left early");
    property p_abort;
        write_abort |-> clr_hist != 6'h3F ##1 !write_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort w/o clear");
    c_soft: cover property (word_valid && w.cmd == CMD_SOFT_RESET);
    c_abort: cover property (write_abort);
    c_clear: cover property ($rose(clear_mode));
endmodule

bind octal_dac_command_control octal_dac_command_control_properties #(
    .CODE_BITS(CODE_BITS),
    .MIDSCALE(MIDSCALE)
) i_octal_dac_command_control_properties (.core_clk, .rst, .word_valid, .word_data,
    .write_busy, .load_strobe_n, .async_clear_n, .dac_code, .amp_on, .term_1k,
    .term_100k, .term_tristate, .ref_on, .clear_mode, .write_abort);

/* tb/word_master.sv */
module word_master
    import dac_ctrl_pkg::*;
(
    input  wire logic        core_clk,   // block clock
    output logic             word_valid, // word complete pulse
    output logic [WORD_W-1:0] word_data, // assembled word
    output logic             write_busy  // transfer in progress
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        word_valid = 1'b0;
        word_data = '0;
        write_busy = 1'b0;
    end
    // called just after a rising edge; slow sends stay busy a while first
    task automatic put(input cmd_word_t w, input bit slow);
        write_busy = 1'b1;
        if (slow) begin
            repeat (3) @(posedge core_clk);
            #1;
        end
        word_data = w;
        word_valid = 1'b1;
        @(posedge core_clk);
        #1;
        word_valid = 1'b0;
        write_busy = 1'b0;
        // released bus must not keep showing the old word
        word_data = ~w;
    endtask
endmodule

/* tb/test_octal_dac_command_control.sv */
module test_octal_dac_command_control
    import dac_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         core_clk = 1'b0;
    logic                         rst = 1'b1;
    logic                         load_strobe_n = 1'b1;
    logic                         async_clear_n = 1'b1;
    logic                         word_valid, write_busy, ref_on, clear_mode, write_abort;
    logic [WORD_W-1:0]            word_data;
    logic [NUM_CHAN*CODE_W-1:0]   dac_code;
    logic [NUM_CHAN-1:0]          amp_on, term_1k, term_100k, term_tristate;
    int                           mismatches = 0;
    int                           samples_checked = 0;
    int                           cycles = 0;
    logic                         abort_seen = 1'b0;
    logic [15:0]                  clr_exp [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'hFFFF};

    octal_dac_command_control i_octal_dac_command_control (.core_clk, .rst, .word_valid,
        .word_data, .write_busy, .load_strobe_n, .async_clear_n, .dac_code, .amp_on,
        .term_1k, .term_100k, .term_tristate, .ref_on, .clear_mode, .write_abort);
    word_master i_word_master (.core_clk, .word_valid, .word_data, .write_busy);

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (write_abort === 1'b1) abort_seen = 1'b1;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic send(input logic [23:0] w);
        i_word_master.put(w, 1'b0);
        step(2);
    endtask

    task automatic t_write();
        send({4'h3, 4'h2, 16'h1234});
        chk(dac_code[47:32], 16'h1234);
        send({4'h0, 4'hF, 16'h5555});
        chk(dac_code[47:32], 16'h1234);
        load_strobe_n = 1'b0;
        step(5);
        chk(dac_code, {8{16'h5555}});
        load_strobe_n = 1'b1;
        send(24'h8A_FFFF);
        chk(ref_on, 1'b1);
        send({4'h6, 4'h0, 16'h0004});
        send({4'h0, 4'hF, 16'hABCD});
        chk(dac_code[47:32], 16'hABCD);
        chk(dac_code[63:48], 16'h5555);
        send({4'h6, 4'h0, 16'h0000});
        $display("write test done");
    endtask
    task automatic t_clear();
        for (int s = 0; s < 4; s++) begin
            if (s > 0) send({4'h5, 4'hA, 14'h3FFF, s[1:0]});
            chk(clear_mode, 1'b0);
            async_clear_n = 1'b0;
            step(6);
            chk(dac_code, {8{clr_exp[s]}});
            chk(clear_mode, s != 3);
            async_clear_n = 1'b1;
            step(2);
        end
        chk(abort_seen, 1'b0);
        $display("clear test done");
    endtask
    task automatic t_pd();
        for (int m = 1; m < 4; m++) begin
            send({4'h4, 4'h5, 6'h3F, m[1:0], 8'h01});
            chk({term_tristate[0], term_100k[0], term_1k[0], amp_on[0]}, 4'h1 << m);
            chk(amp_on[7:1], 7'h7F);
        end
        send({4'h4, 4'h0, 6'h00, 2'h1, 8'hFF});
        chk(ref_on, 1'b0);
        send({4'h0, 4'h0, 16'h2222});
        send({4'h4, 4'h0, 6'h00, 2'h0, 8'h01});
        chk(amp_on, 8'h01);
        chk(ref_on, 1'b1);
        chk(dac_code[15:0], 16'hFFFF);
        load_strobe_n = 1'b0;
        step(5);
        chk(dac_code[15:0], 16'h2222);
        load_strobe_n = 1'b1;
        $display("power-down test done");
    endtask
    task automatic t_abort_soft();
        send(24'h50_0001);
        fork
            i_word_master.put({4'h3, 4'h1, 16'h1111}, 1'b1);
            begin
                step(1);
                async_clear_n = 1'b0;
            end
        join
        step(6);
        chk(abort_seen, 1'b1);
        chk(dac_code[31:16], 16'h8000);
        async_clear_n = 1'b1;
        step(3);
        fork
            i_word_master.put({4'h3, 4'h2, 16'h2222}, 1'b1);
            async_clear_n = 1'b0;
        join
        step(4);
        chk(dac_code[47:32], 16'h8000);
        async_clear_n = 1'b1;
        step(3);
        send(24'h70_0000);
        chk(ref_on, 1'b0);
        chk(amp_on, 8'hFF);
        chk(dac_code, '0);
        chk(clear_mode, 1'b0);
        $display("abort and soft reset test done");
    endtask

    initial begin
        step(2);
        async_clear_n = 1'b0;
        step(2);
        async_clear_n = 1'b1;
        step(2);
        rst = 1'b0;
        step(4);
        chk(dac_code, '0);
        chk(clear_mode, 1'b0);
        chk(ref_on, 1'b0);
        $display("reset test done");
        t_write();
        t_clear();
        t_pd();
        t_abort_soft();
        end_of_test();
    end
endmodule
